/* File: rtl/traffic_gen_mon.sv */
// Packet traffic generator and monitor with APB control and interrupt
//
// Contract
// - Packet carries exactly the requested byte count
// - Error option raises error flag with end
// - Max equal to min means no gap
// - Priority checks available flag only first transfer
// - Alternative variant sends incrementing words
// - Incrementing first word is length; lengths grow
// - Incrementing variant stops at packet quota
// - Gap enable gates writes by random bit (incrementing variant only; data mode waits a gap drawn from wr_gap_r)
// - Monitor flags payload mismatch against pattern
// - Monitor expects identifier one above previous
// - Monitor counts packets, confirms expected count
// - Monitor reports missing start or end
// - Monitor priority mode uses flag first only
// - Identifier in first byte seeds pattern, increments
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module traffic_gen_mon
  import traffic_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [traffic_pkg::AW-1:0] paddr,
  input  wire logic [traffic_pkg::DW-1:0] pwdata,
  output logic      [traffic_pkg::DW-1:0] prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire logic                tx_dav,
  output logic                     tx_ena,
  output logic      [traffic_pkg::DW-1:0] tx_dat,
  output logic                     tx_sop,
  output logic                     tx_eop,
  output logic      [1:0]          tx_mty,
  output logic                     tx_err,
  input  wire logic                rx_dav,
  input  wire logic                rx_val,
  input  wire logic [traffic_pkg::DW-1:0] rx_dat,
  input  wire logic                rx_sop,
  input  wire logic                rx_eop,
  input  wire logic [1:0]          rx_mty,
  output logic                     rx_ena,
  output logic                     mon_err
);
  import traffic_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [31:0]       size_r;
  logic [31:0]       pkt_gap_r;
  logic [31:0]       wr_gap_r;
  logic [31:0]       quota_r;
  logic [31:0]       expect_r;
  logic [IRQ_W-1:0]  irq_sts_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_ev;
  logic              start_r;
  logic [31:0]       rd_mux;
  logic              map_hit;
  logic              wr_en;

  gen_state_t        gst_r;
  logic [26:0]       words_left_r;
  logic [1:0]        last_mty_r;
  logic              first_r;
  logic              pkt_err_r;
  logic [7:0]        id_r;
  logic [GW-1:0]     gap_cnt_r;
  logic              run_r;
  logic [27:0]       inc_len_r;
  logic [31:0]       inc_word_r;
  logic [31:0]       sent_cnt_r;
  logic              ev_sent_r;
  logic              ev_quota_r;
  logic [31:0]       gen_st;
  logic [31:0]       rng_st;
  logic              gen_load;
  logic              gen_adv;
  logic [27:0]       cur_len;
  logic              go;

  logic              in_pkt_r;
  logic              have_id_r;
  logic [7:0]        prev_id_r;
  logic [31:0]       rx_cnt_r;
  logic              reached_r;
  logic              ev_data_r;
  logic              ev_id_r;
  logic              ev_frame_r;
  logic              ev_count_r;
  logic [31:0]       mon_st;
  logic              acc;
  logic [7:0]        rx_id;
  logic [31:0]       rx_mask;
  logic [31:0]       rx_seed;

  // Random span is the random word masked by the difference, so the draw never passes max
  function automatic logic [GW-1:0] draw(input logic [31:0] cfg, input logic [31:0] rnd);
    logic [GW-1:0] lo;
    logic [GW-1:0] hi;
    lo = cfg[GW-1:0];
    hi = cfg[GAP_MAX_LSB +: GW];
    if (hi <= lo) begin
      draw = '0;
    end else begin
      draw = lo + (rnd[GW-1:0] & (hi - lo));
    end
  endfunction

  // APB slave: answer one edge after setup, so prdata can come from a flop
  assign wr_en   = psel & penable & pready & pwrite;
  assign map_hit = (paddr[1:0] == 2'b00) && (paddr <= A_IRQ_MASK);

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      A_CTRL:     rd_mux = {{(32-CTRL_W){1'b0}}, ctrl_r};
      A_SIZE:     rd_mux = size_r;
      A_PKT_GAP:  rd_mux = pkt_gap_r;
      A_WR_GAP:   rd_mux = wr_gap_r;
      A_QUOTA:    rd_mux = quota_r;
      A_EXPECT:   rd_mux = expect_r;
      A_STATUS:   rd_mux = {16'h0000, id_r, 4'h0, mon_err, reached_r, in_pkt_r,
                            (gst_r != G_IDLE) | run_r};
      A_RX_COUNT: rd_mux = rx_cnt_r;
      A_IRQ_STS:  rd_mux = {{(32-IRQ_W){1'b0}}, irq_sts_r};
      A_IRQ_MASK: rd_mux = {{(32-IRQ_W){1'b0}}, irq_mask_r};
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= CTRL_RST;
      size_r     <= '0;
      pkt_gap_r  <= '0;
      wr_gap_r   <= '0;
      quota_r    <= '0;
      expect_r   <= '0;
      irq_mask_r <= '0;
      start_r    <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_en) begin
        unique case (paddr)
          A_CTRL: begin
            ctrl_r  <= pwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << C_START);
            start_r <= pwdata[C_START];
          end
          A_SIZE:     size_r     <= {pwdata[SZ_ERR], 3'b000, pwdata[SZ_W-1:0] & SIZE_MAX};
          A_PKT_GAP:  pkt_gap_r  <= pwdata;
          A_WR_GAP:   wr_gap_r   <= pwdata;
          A_QUOTA:    quota_r    <= pwdata;
          A_EXPECT:   expect_r   <= pwdata;
          A_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
          default:    ;
        endcase
      end
    end
  end

  // Interrupt: sticky status, write one to clear, a new event beats the clear
  assign irq_ev = {ev_count_r, ev_frame_r, ev_id_r, ev_data_r, ev_quota_r, ev_sent_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= '0;
      irq       <= 1'b0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~((wr_en && paddr == A_IRQ_STS) ? pwdata[IRQ_W-1:0] : '0))
                   | irq_ev;
      irq       <= |(irq_sts_r & irq_mask_r);
    end
  end

  // Generator
  assign cur_len  = ctrl_r[C_INCR] ? inc_len_r : size_r[SZ_W-1:0];
  // Incrementing runs launch from run_r only, so a stale length never goes out
  assign gen_load = (gst_r == G_IDLE) && (ctrl_r[C_INCR] ? run_r : start_r)
                    && (cur_len != '0);
  assign gen_adv  = (gst_r == G_WAIT) && go;
  // Priority port ignores the available flag after the first word of a packet
  assign go       = (tx_dav || (ctrl_r[C_PRIO] && !first_r))
                    && !(ctrl_r[C_INCR] && ctrl_r[C_WGAP] && !rng_st[0]);

  prbs_word u_gen_pat (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (gen_load),
    .seed    (lfsr_seed(id_r)),
    .adv     (gen_adv),
    .state   (gen_st)
  );

  prbs_word u_rng (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (1'b0),
    .seed    (RNG_SEED),
    .adv     (1'b1),
    .state   (rng_st)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gst_r        <= G_IDLE;
      words_left_r <= '0;
      last_mty_r   <= '0;
      first_r      <= 1'b0;
      pkt_err_r    <= 1'b0;
      gap_cnt_r    <= '0;
      tx_ena       <= 1'b0;
      tx_dat       <= '0;
      tx_sop       <= 1'b0;
      tx_eop       <= 1'b0;
      tx_mty       <= '0;
      tx_err       <= 1'b0;
      inc_word_r   <= '0;
      ev_sent_r    <= 1'b0;
    end else begin
      tx_ena    <= 1'b0;
      ev_sent_r <= 1'b0;
      unique case (gst_r)
        G_IDLE: begin
          if (gen_load) begin
            words_left_r <= 27'(({2'b00, cur_len} + 30'h000_0003) >> 2);
            last_mty_r   <= 2'(3'd4 - {1'b0, cur_len[1:0]});
            pkt_err_r    <= size_r[SZ_ERR];
            first_r      <= 1'b1;
            inc_word_r   <= 32'h0000_0001;
            gst_r        <= G_WAIT;
          end
        end
        G_WAIT: begin
          if (go) begin
            tx_ena <= 1'b1;
            tx_sop <= first_r;
            tx_eop <= (words_left_r == 27'h000_0001);
            tx_mty <= (words_left_r == 27'h000_0001) ? last_mty_r : 2'b00;
            tx_err <= (words_left_r == 27'h000_0001) & pkt_err_r;
            if (ctrl_r[C_INCR]) begin
              tx_dat     <= first_r ? {4'h0, cur_len} : inc_word_r;
              inc_word_r <= first_r ? inc_word_r : inc_word_r + 32'h0000_0001;
            end else begin
              tx_dat <= first_r ? {id_r, gen_st[23:0]} : gen_st;
            end
            first_r      <= 1'b0;
            words_left_r <= words_left_r - 27'h000_0001;
            gst_r        <= G_SEND;
          end
        end
        G_SEND: begin
          if (words_left_r == '0) begin
            ev_sent_r <= 1'b1;
            gap_cnt_r <= draw(pkt_gap_r, rng_st);
            gst_r     <= G_IPG;
          end else if (ctrl_r[C_WGAP] && !ctrl_r[C_INCR]) begin
            gap_cnt_r <= draw(wr_gap_r, rng_st);
            gst_r     <= G_WGAP;
          end else begin
            gst_r <= G_WAIT;
          end
        end
        G_WGAP: begin
          if (gap_cnt_r == '0) begin
            gst_r <= G_WAIT;
          end else begin
            gap_cnt_r <= gap_cnt_r - GW'(1);
          end
        end
        G_IPG: begin
          if (gap_cnt_r == '0) begin
            gst_r <= G_IDLE;
          end else begin
            gap_cnt_r <= gap_cnt_r - GW'(1);
          end
        end
      endcase
    end
  end

  // Identifier, length growth and quota of the incrementing variant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_r       <= '0;
      run_r      <= 1'b0;
      inc_len_r  <= '0;
      sent_cnt_r <= '0;
      ev_quota_r <= 1'b0;
    end else begin
      ev_quota_r <= 1'b0;
      if (ev_sent_r) begin
        id_r <= id_r + 8'h01;
      end
      if (start_r && ctrl_r[C_INCR] && gst_r == G_IDLE) begin
        run_r      <= (quota_r != '0);
        inc_len_r  <= size_r[SZ_W-1:0];
        sent_cnt_r <= '0;
      end else if (ev_sent_r && run_r) begin
        inc_len_r  <= inc_len_r + 28'h000_0001;
        sent_cnt_r <= sent_cnt_r + 32'h0000_0001;
        if (sent_cnt_r + 32'h0000_0001 == quota_r) begin
          run_r      <= 1'b0;
          ev_quota_r <= 1'b1;
        end
      end
    end
  end

  // Monitor: a word is taken when the read request was high and data is valid
  assign acc     = rx_ena & rx_val;
  assign rx_id   = rx_dat[31:24];
  assign rx_mask = rx_eop ? (32'hFFFF_FFFF << {rx_mty, 3'b000}) : 32'hFFFF_FFFF;
  assign rx_seed = lfsr_seed(rx_id);

  prbs_word u_mon_pat (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (acc & rx_sop),
    .seed    (lfsr_next(rx_seed)),
    .adv     (acc & ~rx_sop & in_pkt_r),
    .state   (mon_st)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ena     <= 1'b0;
      in_pkt_r   <= 1'b0;
      have_id_r  <= 1'b0;
      prev_id_r  <= '0;
      rx_cnt_r   <= '0;
      reached_r  <= 1'b0;
      ev_data_r  <= 1'b0;
      ev_id_r    <= 1'b0;
      ev_frame_r <= 1'b0;
      ev_count_r <= 1'b0;
      mon_err    <= 1'b0;
    end else begin
      // Inside a packet the priority reader keeps pulling whatever the flag says
      rx_ena     <= ctrl_r[C_RX_EN] & (rx_dav | (ctrl_r[C_RX_PRIO] & in_pkt_r));
      ev_data_r  <= 1'b0;
      ev_id_r    <= 1'b0;
      ev_frame_r <= 1'b0;
      ev_count_r <= 1'b0;
      if (acc) begin
        if (rx_sop) begin
          in_pkt_r  <= ~rx_eop;
          have_id_r <= 1'b1;
          prev_id_r <= rx_id;
          ev_frame_r <= in_pkt_r & ctrl_r[C_FCHK];
          ev_id_r   <= have_id_r & ctrl_r[C_IDCHK] & (rx_id != prev_id_r + 8'h01);
          ev_data_r <= ctrl_r[C_DCHK]
                       & ((rx_dat[23:0] & rx_mask[23:0])
                          != (rx_seed[23:0] & rx_mask[23:0]));
        end else if (!in_pkt_r) begin
          ev_frame_r <= ctrl_r[C_FCHK];
        end else begin
          in_pkt_r  <= ~rx_eop;
          ev_data_r <= ctrl_r[C_DCHK] & ((rx_dat & rx_mask) != (mon_st & rx_mask));
        end
        if (rx_eop && (rx_sop || in_pkt_r)) begin
          rx_cnt_r <= rx_cnt_r + 32'h0000_0001;
          if (rx_cnt_r + 32'h0000_0001 == expect_r) begin
            reached_r  <= 1'b1;
            ev_count_r <= 1'b1;
          end
        end
      end
      if (ev_data_r | ev_id_r | ev_frame_r) begin
        mon_err <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: inc/traffic_pkg.sv */
// Constants, register map and pattern functions for the traffic generator and monitor
package traffic_pkg;
  localparam int          DW          = 32;
  localparam int          AW          = 8;
  localparam int          GW          = 16;
  // Register byte offsets
  localparam logic [7:0]  A_CTRL      = 8'h00;
  localparam logic [7:0]  A_SIZE      = 8'h04;
  localparam logic [7:0]  A_PKT_GAP   = 8'h08;
  localparam logic [7:0]  A_WR_GAP    = 8'h0C;
  localparam logic [7:0]  A_QUOTA     = 8'h10;
  localparam logic [7:0]  A_EXPECT    = 8'h14;
  localparam logic [7:0]  A_STATUS    = 8'h18;
  localparam logic [7:0]  A_RX_COUNT  = 8'h1C;
  localparam logic [7:0]  A_IRQ_STS   = 8'h20;
  localparam logic [7:0]  A_IRQ_MASK  = 8'h24;
  // Control bits
  localparam int          C_START     = 0;
  localparam int          C_PRIO      = 1;
  localparam int          C_INCR      = 2;
  localparam int          C_WGAP      = 3;
  localparam int          C_RX_PRIO   = 4;
  localparam int          C_RX_EN     = 5;
  localparam int          C_DCHK      = 6;
  localparam int          C_IDCHK     = 7;
  localparam int          C_FCHK      = 8;
  localparam int          CTRL_W      = 9;
  localparam logic [8:0]  CTRL_RST    = 9'h1E0;
  // Size register: byte count and error option
  localparam int          SZ_W        = 28;
  localparam logic [27:0] SIZE_MAX    = 28'hFFF_FFFF;
  localparam int          SZ_ERR      = 31;
  localparam int          GAP_MAX_LSB = 16;
  // Interrupt status bits
  localparam int          I_SENT      = 0;
  localparam int          I_QUOTA     = 1;
  localparam int          I_DATA      = 2;
  localparam int          I_ID        = 3;
  localparam int          I_FRAME     = 4;
  localparam int          I_COUNT     = 5;
  localparam int          IRQ_W       = 6;
  // Status register fields
  localparam int          S_BUSY      = 0;
  localparam int          S_IN_PKT    = 1;
  localparam int          S_REACHED   = 2;
  localparam int          S_ERR       = 3;
  localparam int          S_ID_LSB    = 8;
  // Pattern generator
  localparam logic [31:0] LFSR_POLY   = 32'h04C1_1DB7;
  localparam logic [31:0] SEED_MIX    = 32'h5A5A_5A5B;
  localparam logic [31:0] RNG_SEED    = 32'h0000_ACE1;

  typedef enum logic [2:0] {G_IDLE, G_WAIT, G_SEND, G_WGAP, G_IPG} gen_state_t;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? LFSR_POLY : 32'h0000_0000);
  endfunction

  // Never zero for any identifier, so the sequence cannot lock up
  function automatic logic [31:0] lfsr_seed(input logic [7:0] id);
    lfsr_seed = {id, id, id, id} ^ SEED_MIX;
  endfunction
endpackage

/* File: rtl/prbs_word.sv */
// Loadable 32-bit pattern register stepping one word per advance
`timescale 1ns/1ps
`default_nettype none
module prbs_word
  import traffic_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [31:0] seed,
  input  wire logic        adv,
  output logic      [31:0] state
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RNG_SEED;
    end else if (load) begin
      state <= seed;
    end else if (adv) begin
      state <= lfsr_next(state);
    end
  end
endmodule
`default_nettype wire

/* File: tb/traffic_sva.sv */
// Port checker for the traffic generator and monitor
`timescale 1ns/1ps
`default_nettype none
module traffic_sva
  import traffic_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [traffic_pkg::DW-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        tx_dav,
  input wire logic                        tx_ena,
  input wire logic [traffic_pkg::DW-1:0]  tx_dat,
  input wire logic                        tx_sop,
  input wire logic                        tx_eop,
  input wire logic [1:0]                  tx_mty,
  input wire logic                        tx_err,
  input wire logic                        mon_err
);
  logic in_pkt_r;

  // Tracks framing of the outgoing stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      in_pkt_r <= 1'b0;
    else if (tx_ena)
      in_pkt_r <= !tx_eop;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_next: assert property (psel && !penable |=> pready) else $error("no pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero");
  a_word_gap: assert property (tx_ena |=> !tx_ena) else $error("words too close");
  a_err_on_end: assert property (tx_ena && tx_err |-> tx_eop)
    else $error("error flag off end");
  a_mty_on_end: assert property (tx_ena && !tx_eop |-> tx_mty == 2'h0)
    else $error("empty bytes mid packet");
  a_sop_opens: assert property (tx_ena && !in_pkt_r |-> tx_sop)
    else $error("packet without start");
  a_sop_once: assert property (tx_ena && in_pkt_r |-> !tx_sop)
    else $error("start inside packet");
  a_dav_first: assert property (tx_ena && tx_sop |-> $past(tx_dav))
    else $error("start without available");
  a_err_sticky: assert property (mon_err |=> mon_err)
    else $error("monitor error dropped");
  a_fields_hold: assert property (!tx_ena |-> $stable(tx_dat)) else $error("data moved");

  c_err_end: cover property (tx_ena && tx_eop && tx_err);
  c_slverr: cover property (pslverr);
  c_mon_err: cover property ($rose(mon_err));
endmodule

bind traffic_gen_mon traffic_sva traffic_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_dav(tx_dav),
  .tx_ena(tx_ena), .tx_dat(tx_dat), .tx_sop(tx_sop), .tx_eop(tx_eop),
  .tx_mty(tx_mty), .tx_err(tx_err), .mon_err(mon_err)
);
`default_nettype wire

/* File: tb/link_partner.sv */
// Loopback model of the link core user ports, with commanded faults
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic [1:0]  fault,
  output logic             tx_dav,
  input  wire logic        tx_ena,
  input  wire logic [31:0] tx_dat,
  input  wire logic        tx_sop,
  input  wire logic        tx_eop,
  input  wire logic [1:0]  tx_mty,
  output logic             rx_dav,
  output logic             rx_val,
  output logic      [31:0] rx_dat,
  output logic             rx_sop,
  output logic             rx_eop,
  output logic      [1:0]  rx_mty,
  input  wire logic        rx_ena
);
  logic [35:0] q[$];
  logic [35:0] w;
  logic [1:0]  arm_r;
  logic        skip_r;
  logic        sk;

  assign tx_dav = !stall;
  assign rx_dav = rx_val;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      arm_r <= 2'h0;
      skip_r <= 1'b0;
      rx_val <= 1'b0;
      {rx_mty, rx_eop, rx_sop, rx_dat} <= 36'h0;
    end else begin
      // Idle data toggles so a stale word never looks valid
      if (!rx_val || rx_ena) begin
        rx_val <= q.size() > 0;
        if (q.size() > 0)
          {rx_mty, rx_eop, rx_sop, rx_dat} <= q.pop_front();
        else
          rx_dat <= ~rx_dat;
      end
      if (fault != 2'h0)
        arm_r <= fault;
      if (tx_ena) begin
        w = {tx_mty, tx_eop, tx_sop, tx_dat};
        sk = (arm_r == 2'h3 && tx_sop) || skip_r;
        skip_r <= sk && !tx_eop;
        if (arm_r == 2'h1 && !tx_sop) begin
          w[0] = ~w[0];
          arm_r <= 2'h0;
        end
        if (arm_r[1] && tx_sop) begin
          w[32] = arm_r[0];
          arm_r <= 2'h0;
        end
        if (!sk)
          q.push_back(w);
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/packet_traffic_gen_monitor_bench.sv */
// Self-checking bench for the traffic generator and monitor
`timescale 1ns/1ps
`default_nettype none
module packet_traffic_gen_monitor_bench;
  import traffic_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, stall, se;
  logic        tx_dav, tx_ena, tx_sop, tx_eop, tx_err, rx_dav, rx_val, rx_sop, rx_eop;
  logic        rx_ena, mon_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, tx_dat, rx_dat, rd;
  logic [1:0]  tx_mty, rx_mty, fault;
  logic [36:0] txq[$];
  int          err_count, n_compared, n;

  traffic_gen_mon traffic_gen_mon_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .tx_dav(tx_dav), .tx_ena(tx_ena),
    .tx_dat(tx_dat), .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_mty(tx_mty), .tx_err(tx_err),
    .rx_dav(rx_dav), .rx_val(rx_val), .rx_dat(rx_dat), .rx_sop(rx_sop), .rx_eop(rx_eop),
    .rx_mty(rx_mty), .rx_ena(rx_ena), .mon_err(mon_err));
  link_partner link_partner_i (.pclk(pclk), .presetn(presetn), .stall(stall),
    .fault(fault), .tx_dav(tx_dav), .tx_ena(tx_ena), .tx_dat(tx_dat), .tx_sop(tx_sop),
    .tx_eop(tx_eop), .tx_mty(tx_mty), .rx_dav(rx_dav), .rx_val(rx_val), .rx_dat(rx_dat),
    .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_mty(rx_mty), .rx_ena(rx_ena));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (tx_ena)
      txq.push_back({tx_err, tx_mty, tx_eop, tx_sop, tx_dat});

  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [36:0] g, input logic [36:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({5'h00, rd & m}, {5'h00, e});
  endtask

  task idle;
    n = 0;
    do begin
      apb(1'b0, A_STATUS, 32'h0);
      n++;
    end while (rd[S_BUSY] !== 1'b0 && n < 300);
    chk({36'h0, rd[S_BUSY]}, 37'h0);
    repeat (20) @(posedge pclk);
  endtask

  task send(input logic [31:0] sz, input logic [31:0] ctl);
    apb(1'b1, A_SIZE, sz);
    apb(1'b1, A_CTRL, ctl);
    idle();
  endtask

  // Expected words worked out independently of the design's own helpers
  task pkt(input logic [7:0] id, input int sz, input logic er, input logic inc);
    logic [31:0] s, x;
    logic        l;
    int          nw;
    nw = (sz + 3) / 4;
    s = {4{id}} ^ SEED_MIX;
    for (int k = 0; k < nw; k++) begin
      l = (k == nw - 1);
      x = inc ? (k == 0 ? 32'(sz) : 32'(k)) : (k == 0 ? {id, s[23:0]} : s);
      chk(txq.size() > 0 ? txq.pop_front() : 37'h0,
          {er && l, l ? 2'((4 - sz % 4) % 4) : 2'h0, l, k == 0, x});
      s = {s[30:0], 1'b0} ^ (s[31] ? LFSR_POLY : 32'h0000_0000);
    end
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stall, fault} = '0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_CTRL, 32'h0000_01FF, 32'h0000_01E0);
    rdc(A_IRQ_STS, 32'h0000_003F, 32'h0000_0000);
    apb(1'b0, 8'h28, 32'h0);
    chk({36'h0, se}, 37'h1);
    apb(1'b1, A_EXPECT, 32'h0000_0003);
    apb(1'b1, A_PKT_GAP, 32'h0003_0003);
    send(32'h8000_0007, 32'h0000_01E1);
    pkt(8'h00, 7, 1'b1, 1'b0);
    chk({36'h0, irq}, 37'h0);
    apb(1'b1, A_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({36'h0, irq}, 37'h1);
    apb(1'b1, A_IRQ_STS, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({36'h0, irq}, 37'h0);
    // Data mode: nothing may leave while the far side is full
    stall <= 1'b1;
    apb(1'b1, A_PKT_GAP, 32'h0008_0002);
    apb(1'b1, A_SIZE, 32'h0000_0008);
    apb(1'b1, A_CTRL, 32'h0000_01E1);
    repeat (10) @(posedge pclk);
    chk(37'(txq.size()), 37'h0);
    stall <= 1'b0;
    idle();
    pkt(8'h01, 8, 1'b0, 1'b0);
    // Priority mode: only the first word waits for space
    stall <= 1'b1;
    apb(1'b1, A_WR_GAP, 32'h0006_0001);
    apb(1'b1, A_SIZE, 32'h0000_000C);
    apb(1'b1, A_CTRL, 32'h0000_01FB);
    repeat (10) @(posedge pclk);
    chk(37'(txq.size()), 37'h0);
    stall <= 1'b0;
    n = 0;
    while (tx_ena !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    stall <= 1'b1;
    idle();
    stall <= 1'b0;
    pkt(8'h02, 12, 1'b0, 1'b0);
    rdc(A_RX_COUNT, 32'hFFFF_FFFF, 32'h0000_0003);
    rdc(A_STATUS, 32'h0000_000C, 32'h0000_0004);
    // Incrementing variant with gated writes, checks that need the pattern off
    apb(1'b1, A_QUOTA, 32'h0000_0003);
    send(32'h0000_0005, 32'h0000_012D);
    for (int i = 0; i < 3; i++)
      pkt(8'h00, 5 + i, 1'b0, 1'b1);
    chk(37'(txq.size()), 37'h0);
    rdc(A_IRQ_STS, 32'h0000_0002, 32'h0000_0002);
    fault <= 2'h1;
    @(posedge pclk);
    fault <= 2'h0;
    send(32'h0000_0008, 32'h0000_01E1);
    pkt(8'h06, 8, 1'b0, 1'b0);
    rdc(A_IRQ_STS, 32'h0000_0004, 32'h0000_0004);
    chk({36'h0, mon_err}, 37'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({36'h0, mon_err}, 37'h0);
    presetn <= 1'b1;
    // Lost packet breaks the identifier order, then a start marker goes missing
    for (int i = 0; i < 4; i++) begin
      fault <= i == 1 ? 2'h3 : (i == 3 ? 2'h2 : 2'h0);
      @(posedge pclk);
      fault <= 2'h0;
      send(32'h0000_0008, 32'h0000_01E1);
      pkt(8'(i), 8, 1'b0, 1'b0);
    end
    rdc(A_IRQ_STS, 32'h0000_001C, 32'h0000_0018);
    results();
  end
endmodule
`default_nettype wire
